// >>> pkg/iam_pkg.sv
// Constants and types shared by the installation angle compensation block
// What this block does
// - Reading the level capture trigger entry always returns the value No.
// - Writing Yes to the level capture trigger updates both initial pitch and roll offsets.
// - Initial pitch and roll offsets accept direct host writes as well as capture results.
// - Initial pitch and roll offsets rotate accelerations from the unit frame to the machine frame.
// - Frame rotation angles re-orient the unit frame as Euler angles in yaw, pitch, roll order.
// - Frame rotation angles anywhere in the signed half-turn range are accepted and used.
// - A true vertical mount select re-maps the unit frame for a vertically mounted unit.
package iam_pkg;

  // ==========================================================================
  // Widths and object dictionary indices
  localparam int          VW                 = 22;
  localparam logic [15:0] IDX_INIT_PITCH     = 16'h2200;
  localparam logic [15:0] IDX_INIT_ROLL      = 16'h2210;
  localparam logic [15:0] IDX_VERTICAL_MOUNT = 16'h2220;
  localparam logic [15:0] IDX_ROT_YAW        = 16'h2230;
  localparam logic [15:0] IDX_ROT_PITCH      = 16'h2240;
  localparam logic [15:0] IDX_ROT_ROLL       = 16'h2250;
  localparam logic [15:0] IDX_LEVEL_CAPTURE  = 16'h2300;
  localparam logic [7:0]  SUBIDX_VALUE       = 8'h00;

  // ==========================================================================
  // Reset values and command codes
  localparam logic [31:0] RST_ANGLE  = 32'h0000_0000;
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [7:0]  LEVEL_NO   = 8'h00;
  localparam logic [7:0]  LEVEL_YES  = 8'h01;

  // ==========================================================================
  // Angle arithmetic, degrees in signed Q16.16
  localparam logic signed [31:0] DEG90     = 32'sh005a_0000;
  localparam logic signed [31:0] DEG180    = 32'sh00b4_0000;
  localparam logic signed [31:0] HALF_LSB  = 32'sh0000_8000;
  localparam logic [16:0]        KGAIN     = 17'h09b75;
  localparam logic [3:0]         LAST_ITER = 4'hf;
  localparam logic signed [31:0] ATAN [16] = '{
    32'sh002d0000, 32'sh001a90a7, 32'sh000e0947, 32'sh00072001,
    32'sh0003938b, 32'sh0001ca38, 32'sh0000e52a, 32'sh00007297,
    32'sh0000394c, 32'sh00001ca6, 32'sh00000e53, 32'sh00000729,
    32'sh00000395, 32'sh000001ca, 32'sh000000e5, 32'sh00000073};

  typedef enum logic [6:0] {
    S_IDLE  = 7'b000_0001,
    S_ISSUE = 7'b000_0010,
    S_WAIT  = 7'b000_0100,
    S_CAPR  = 7'b000_1000,
    S_CAPP  = 7'b001_0000,
    S_STORE = 7'b010_0000,
    S_OUT   = 7'b100_0000
  } iam_state_t;

endpackage : iam_pkg

// >>> pkg/iam_cordic_if.sv
// Request and answer bundle between the sequencer and the CORDIC engine
`timescale 1ns/1ps
`default_nettype none
interface iam_cordic_if;
  import iam_pkg::*;
  logic                 start;
  logic                 vec;
  logic signed [VW-1:0] xi;
  logic signed [VW-1:0] yi;
  logic signed [31:0]   zi;
  logic                 done;
  logic signed [VW-1:0] xo;
  logic signed [VW-1:0] yo;
  logic signed [31:0]   zo;
  modport engine (input start, vec, xi, yi, zi, output done, xo, yo, zo);
  modport client (output start, vec, xi, yi, zi, input done, xo, yo, zo);
endinterface : iam_cordic_if
`default_nettype wire

// >>> logic/iam_cordic.sv
// Iterative CORDIC for vector rotation and angle extraction
`timescale 1ns/1ps
`default_nettype none
module iam_cordic import iam_pkg::*; (
  input wire logic     sys_clk,
  input wire logic     reset_n,
  iam_cordic_if.engine cif
);

  // Guard bits keep the truncation error of chained passes to a few LSB
  localparam int        GB = 4;
  logic                 busy;
  logic                 fin;
  logic                 vmode;
  logic [3:0]           iter;
  logic signed [VW-1:0] x;
  logic signed [VW-1:0] y;
  logic signed [31:0]   z;
  logic signed [VW-1:0] xs;
  logic signed [VW-1:0] ys;
  logic                 cw;
  logic signed [VW+16:0] px;
  logic signed [VW+16:0] py;

  assign xs = x >>> iter;
  assign ys = y >>> iter;
  assign cw = vmode ? ~y[VW-1] : z[31];
  // Gain is removed once at the end, so every answer is unit-gain
  assign px = x * $signed({1'b0, KGAIN});
  assign py = y * $signed({1'b0, KGAIN});

  // ==========================================================================
  // Iterations; quadrant folding keeps the full half-turn range usable
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy  <= 1'b0;
      vmode <= 1'b0;
      iter  <= 4'h0;
      x     <= '0;
      y     <= '0;
      z     <= '0;
    end else if (cif.start && !busy && !fin && !cif.done) begin
      // Start is a level in the capture steps; answer cycles must not relaunch
      busy  <= 1'b1;
      vmode <= cif.vec;
      iter  <= 4'h0;
      if (cif.vec && cif.xi < 0) begin
        x <= -(cif.xi <<< GB);
        y <= -(cif.yi <<< GB);
        z <= cif.yi[VW-1] ? -DEG180 : DEG180;
      end else if (cif.vec) begin
        x <= cif.xi <<< GB;
        y <= cif.yi <<< GB;
        z <= '0;
      end else if (cif.zi > DEG90 || cif.zi < -DEG90) begin
        x <= -(cif.xi <<< GB);
        y <= -(cif.yi <<< GB);
        z <= cif.zi[31] ? cif.zi + DEG180 : cif.zi - DEG180;
      end else begin
        x <= cif.xi <<< GB;
        y <= cif.yi <<< GB;
        z <= cif.zi;
      end
    end else if (busy) begin
      if (cw) begin
        x <= x + ys;
        y <= y - xs;
        z <= z + ATAN[iter];
      end else begin
        x <= x - ys;
        y <= y + xs;
        z <= z - ATAN[iter];
      end
      iter <= iter + 4'h1;
      if (iter == LAST_ITER) begin
        busy <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Answer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fin    <= 1'b0;
      cif.done <= 1'b0;
      cif.xo <= '0;
      cif.yo <= '0;
      cif.zo <= '0;
    end else begin
      fin      <= busy && iter == LAST_ITER;
      cif.done <= fin;
      if (fin) begin
        cif.xo <= VW'(px >>> (16 + GB));
        cif.yo <= VW'(py >>> (16 + GB));
        cif.zo <= z;
      end
    end
  end

endmodule : iam_cordic
`default_nettype wire

// >>> logic/iam_mount_map.sv
// Sample register with horizontal or vertical mount axis mapping
`timescale 1ns/1ps
`default_nettype none
module iam_mount_map import iam_pkg::*; (
  input  wire logic               sys_clk,
  input  wire logic               reset_n,
  input  wire logic               vertical,
  input  wire logic               in_valid,
  input  wire logic signed [15:0] in_x,
  input  wire logic signed [15:0] in_y,
  input  wire logic signed [15:0] in_z,
  output logic                    out_valid,
  output logic signed [VW-1:0]    out_x,
  output logic signed [VW-1:0]    out_y,
  output logic signed [VW-1:0]    out_z
);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_valid <= 1'b0;
      out_x     <= '0;
      out_y     <= '0;
      out_z     <= '0;
    end else begin
      out_valid <= in_valid;
      if (in_valid && vertical) begin
        // Yaw then pitch of a quarter turn is a cyclic axis swap
        out_x <= VW'(in_y);
        out_y <= VW'(in_z);
        out_z <= VW'(in_x);
      end else if (in_valid) begin
        out_x <= VW'(in_x);
        out_y <= VW'(in_y);
        out_z <= VW'(in_z);
      end
    end
  end

endmodule : iam_mount_map
`default_nettype wire

// >>> logic/iam_install_comp.sv
// Installation angle compensation: dictionary entries and frame sequencer
`timescale 1ns/1ps
`default_nettype none
module iam_install_comp import iam_pkg::*; (
  input  wire logic               sys_clk,
  input  wire logic               reset_n,
  input  wire logic [15:0]        od_index,
  input  wire logic [7:0]         od_subindex,
  input  wire logic               od_write,
  input  wire logic               od_read,
  input  wire logic [31:0]        od_wdata,
  output logic [31:0]             od_rdata,
  output logic                    od_rvalid,
  input  wire logic               accel_valid,
  input  wire logic signed [15:0] accel_x,
  input  wire logic signed [15:0] accel_y,
  input  wire logic signed [15:0] accel_z,
  output logic                    machine_valid,
  output logic signed [VW-1:0]    machine_x,
  output logic signed [VW-1:0]    machine_y,
  output logic signed [VW-1:0]    machine_z,
  output logic                    capture_busy
);

  // ==========================================================================
  // Declarations
  iam_state_t           state;
  logic [2:0]           step;
  logic [31:0]          initial_pitch_offset;
  logic [7:0]           initial_roll_offset;
  logic [7:0]           vertical_mount_select;
  logic [31:0]          frame_rotation_yaw;
  logic [31:0]          frame_rotation_pitch;
  logic [31:0]          frame_rotation_roll;
  logic                 wr_sel;
  logic                 rd_sel;
  logic                 cap_set;
  logic                 cap_store;
  logic signed [VW-1:0] vx;
  logic signed [VW-1:0] vy;
  logic signed [VW-1:0] vz;
  logic signed [VW-1:0] mag;
  logic signed [31:0]   roll_cap;
  logic signed [31:0]   pitch_cap;
  logic signed [31:0]   roll_round;
  logic signed [31:0]   roll_q16;
  logic                 map_valid;
  logic signed [VW-1:0] map_x;
  logic signed [VW-1:0] map_y;
  logic signed [VW-1:0] map_z;

  iam_cordic_if cif ();

  // ==========================================================================
  // Leaf instances
  iam_cordic u_cordic (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .cif     (cif.engine)
  );

  iam_mount_map u_mount_map (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .vertical  (|vertical_mount_select),
    .in_valid  (accel_valid),
    .in_x      (accel_x),
    .in_y      (accel_y),
    .in_z      (accel_z),
    .out_valid (map_valid),
    .out_x     (map_x),
    .out_y     (map_y),
    .out_z     (map_z)
  );

  // ==========================================================================
  // Dictionary access decode
  assign wr_sel    = od_write && od_subindex == SUBIDX_VALUE;
  assign rd_sel    = od_read && od_subindex == SUBIDX_VALUE;
  assign cap_set   = wr_sel && od_index == IDX_LEVEL_CAPTURE && od_wdata[7:0] == LEVEL_YES;
  assign cap_store = state == S_STORE;
  // Roll entry is one byte of whole degrees, so the capture is rounded
  assign roll_round = (roll_cap + HALF_LSB) >>> 16;
  assign roll_q16   = {{8{initial_roll_offset[7]}}, initial_roll_offset, 16'h0000};

  // ==========================================================================
  // Configuration entries
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      initial_pitch_offset  <= RST_ANGLE;
      initial_roll_offset   <= RST_BYTE;
      vertical_mount_select <= RST_BYTE;
      frame_rotation_yaw    <= RST_ANGLE;
      frame_rotation_pitch  <= RST_ANGLE;
      frame_rotation_roll   <= RST_ANGLE;
    end else begin
      if (wr_sel) begin
        case (od_index)
          IDX_INIT_PITCH: begin
            initial_pitch_offset <= od_wdata;
          end
          IDX_INIT_ROLL: begin
            initial_roll_offset <= od_wdata[7:0];
          end
          IDX_VERTICAL_MOUNT: begin
            vertical_mount_select <= od_wdata[7:0];
          end
          IDX_ROT_YAW: begin
            frame_rotation_yaw <= od_wdata;
          end
          IDX_ROT_PITCH: begin
            frame_rotation_pitch <= od_wdata;
          end
          IDX_ROT_ROLL: begin
            frame_rotation_roll <= od_wdata;
          end
          default: begin
          end
        endcase
      end
      // Only offset writes in the store cycle are lost; capture wins
      if (cap_store) begin
        initial_pitch_offset <= pitch_cap;
        initial_roll_offset  <= roll_round[7:0];
      end
    end
  end

  // ==========================================================================
  // Capture request; a new Yes in the clearing cycle keeps it pending
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      capture_busy <= 1'b0;
    end else if (cap_set) begin
      capture_busy <= 1'b1;
    end else if (cap_store) begin
      capture_busy <= 1'b0;
    end
  end

  // ==========================================================================
  // Read answers, one cycle after the strobe
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      od_rvalid <= 1'b0;
      od_rdata  <= '0;
    end else begin
      od_rvalid <= od_read;
      if (od_read) begin
        od_rdata <= '0;
        if (rd_sel) begin
          case (od_index)
            IDX_INIT_PITCH: begin
              od_rdata <= initial_pitch_offset;
            end
            IDX_INIT_ROLL: begin
              od_rdata <= {24'h00_0000, initial_roll_offset};
            end
            IDX_VERTICAL_MOUNT: begin
              od_rdata <= {24'h00_0000, vertical_mount_select};
            end
            IDX_ROT_YAW: begin
              od_rdata <= frame_rotation_yaw;
            end
            IDX_ROT_PITCH: begin
              od_rdata <= frame_rotation_pitch;
            end
            IDX_ROT_ROLL: begin
              od_rdata <= frame_rotation_roll;
            end
            IDX_LEVEL_CAPTURE: begin
              od_rdata <= {24'h00_0000, LEVEL_NO};
            end
            default: begin
              od_rdata <= '0;
            end
          endcase
        end
      end
    end
  end

  // ==========================================================================
  // Engine request per step: a frame change turns the vector the other way
  always_comb begin
    cif.start = state == S_ISSUE || state == S_CAPR || state == S_CAPP;
    cif.vec   = state != S_ISSUE;
    cif.xi    = vz;
    cif.yi    = vy;
    cif.zi    = '0;
    case (state)
      S_CAPR: begin
        cif.xi = vz;
        cif.yi = vy;
      end
      S_CAPP: begin
        cif.xi = mag;
        cif.yi = vx;
      end
      default: begin
        case (step)
          3'd0: begin
            cif.xi = vx;
            cif.yi = vy;
            cif.zi = -frame_rotation_yaw;
          end
          3'd1: begin
            cif.xi = vz;
            cif.yi = vx;
            cif.zi = -frame_rotation_pitch;
          end
          3'd2: begin
            cif.zi = -frame_rotation_roll;
          end
          3'd3: begin
            cif.zi = -roll_q16;
          end
          default: begin
            cif.xi = vz;
            cif.yi = vx;
            cif.zi = -initial_pitch_offset;
          end
        endcase
      end
    endcase
  end

  // ==========================================================================
  // Sequencer: mount map, frame rotation, optional capture, then offsets
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state     <= S_IDLE;
      step      <= 3'd0;
      vx        <= '0;
      vy        <= '0;
      vz        <= '0;
      mag       <= '0;
      roll_cap  <= '0;
      pitch_cap <= '0;
    end else begin
      case (state)
        S_IDLE: begin
          // Samples arriving while busy are dropped, not queued
          if (map_valid) begin
            vx    <= map_x;
            vy    <= map_y;
            vz    <= map_z;
            step  <= 3'd0;
            state <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          state <= S_WAIT;
        end
        S_WAIT: begin
          if (cif.done) begin
            case (step)
              3'd0: begin
                vx <= cif.xo;
                vy <= cif.yo;
              end
              3'd1, 3'd4: begin
                vz <= cif.xo;
                vx <= cif.yo;
              end
              default: begin
                vz <= cif.xo;
                vy <= cif.yo;
              end
            endcase
            step <= step + 3'd1;
            if (step == 3'd2 && capture_busy) begin
              state <= S_CAPR;
            end else if (step == 3'd4) begin
              state <= S_OUT;
            end else begin
              state <= S_ISSUE;
            end
          end
        end
        S_CAPR: begin
          if (cif.done) begin
            roll_cap <= cif.zo;
            mag      <= cif.xo;
            state    <= S_CAPP;
          end
        end
        S_CAPP: begin
          if (cif.done) begin
            pitch_cap <= cif.zo;
            state     <= S_STORE;
          end
        end
        S_STORE: begin
          state <= S_ISSUE;
        end
        S_OUT: begin
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Machine frame result
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      machine_valid <= 1'b0;
      machine_x     <= '0;
      machine_y     <= '0;
      machine_z     <= '0;
    end else begin
      machine_valid <= state == S_OUT;
      if (state == S_OUT) begin
        machine_x <= vx;
        machine_y <= vy;
        machine_z <= vz;
      end
    end
  end

endmodule : iam_install_comp
`default_nettype wire

// >>> testbench/iam_install_comp_checker.sv
// Port-level assertions for the installation angle compensation block
`timescale 1ns/1ps
`default_nettype none
module iam_install_comp_checker import iam_pkg::*; (
  input wire logic                 sys_clk,
  input wire logic                 reset_n,
  input wire logic [15:0]          od_index,
  input wire logic [7:0]           od_subindex,
  input wire logic                 od_write,
  input wire logic                 od_read,
  input wire logic [31:0]          od_wdata,
  input wire logic [31:0]          od_rdata,
  input wire logic                 od_rvalid,
  input wire logic                 machine_valid,
  input wire logic signed [VW-1:0] machine_x,
  input wire logic signed [VW-1:0] machine_y,
  input wire logic signed [VW-1:0] machine_z,
  input wire logic                 capture_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic cap_hit;
  logic yes_wr;
  assign cap_hit = od_index == IDX_LEVEL_CAPTURE && od_subindex == SUBIDX_VALUE;
  assign yes_wr  = od_write && cap_hit && od_wdata[7:0] == LEVEL_YES;

  // ====================================================
  // Assertions
  read_answer_a: assert property (od_read |=> od_rvalid)
    else $error("read strobe got no answer");
  answer_cause_a: assert property (od_rvalid |-> $past(od_read))
    else $error("answer without a read strobe");
  capture_reads_no_a: assert property (od_read && cap_hit |=> od_rdata == {24'h0, LEVEL_NO})
    else $error("capture entry did not read No");
  bad_sub_zero_a: assert property (od_read && od_subindex != SUBIDX_VALUE |=> od_rdata == 32'h0)
    else $error("bad subindex read not zero");
  rdata_hold_a: assert property (!od_rvalid |-> $stable(od_rdata))
    else $error("read data moved without answer");
  yes_sets_busy_a: assert property (yes_wr |=> capture_busy)
    else $error("capture did not start");
  busy_cause_a: assert property ($rose(capture_busy) |-> $past(yes_wr))
    else $error("capture started without command");
  valid_pulse_a: assert property (machine_valid |=> !machine_valid)
    else $error("machine sample longer than one cycle");
  output_hold_a: assert property (!machine_valid |-> $stable({machine_x, machine_y, machine_z}))
    else $error("machine sample moved without valid");
  cover property (yes_wr);
  cover property (od_read && cap_hit);
  cover property ($fell(capture_busy));
endmodule : iam_install_comp_checker
bind iam_install_comp iam_install_comp_checker u_chk (.sys_clk, .reset_n, .od_index, .od_subindex,
  .od_write, .od_read, .od_wdata, .od_rdata, .od_rvalid, .machine_valid, .machine_x, .machine_y,
  .machine_z, .capture_busy);
`default_nettype wire

// >>> testbench/iam_host_model.sv
// Network host model issuing dictionary reads and writes
`timescale 1ns/1ps
`default_nettype none
module iam_host_model import iam_pkg::*; (
  input  wire logic        sys_clk,
  output var logic [15:0]  od_index,
  output var logic [7:0]   od_subindex,
  output var logic         od_write,
  output var logic         od_read,
  output var logic [31:0]  od_wdata,
  input  wire logic [31:0] od_rdata,
  input  wire logic        od_rvalid
);
  initial begin
    od_index = 16'h0;
    od_subindex = 8'h0;
    od_write = 1'b0;
    od_read = 1'b0;
    od_wdata = 32'h0;
  end

  // ====================================================
  // Bus cycles; released lines flip so stale data never looks valid
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    @(posedge sys_clk);
    #1;
    od_index = idx;
    od_subindex = SUBIDX_VALUE;
    od_wdata = d;
    od_write = 1'b1;
    @(posedge sys_clk);
    #1;
    od_write = 1'b0;
    od_wdata = ~d;
    od_index = ~idx;
  endtask : wr

  task automatic rd(input logic [15:0] idx, input logic [7:0] sub, output logic [31:0] d, output logic v);
    @(posedge sys_clk);
    #1;
    od_index = idx;
    od_subindex = sub;
    od_read = 1'b1;
    @(posedge sys_clk);
    #1;
    od_read = 1'b0;
    od_index = ~idx;
    d = od_rdata;
    v = od_rvalid;
  endtask : rd

  // Caller holds the machine level and clear of gimbal lock
  task automatic capture();
    wr(IDX_LEVEL_CAPTURE, {24'h0, LEVEL_YES});
  endtask : capture
endmodule : iam_host_model
`default_nettype wire

// >>> testbench/test_installation_angle_compensation.sv
// Self-checking bench for the installation angle compensation block
`timescale 1ns/1ps
`default_nettype none
module test_installation_angle_compensation import iam_pkg::*;;
  logic                 sys_clk = 1'b0;
  logic                 reset_n;
  logic [15:0]          od_index;
  logic [7:0]           od_subindex;
  logic                 od_write, od_read, od_rvalid;
  logic [31:0]          od_wdata, od_rdata;
  logic                 accel_valid, machine_valid, capture_busy;
  logic signed [15:0]   accel_x, accel_y, accel_z;
  logic signed [VW-1:0] machine_x, machine_y, machine_z;
  int                   err_total = 0;
  int                   n_compared = 0;
  logic [15:0]          idx_tab [7];

  iam_install_comp DUT (.sys_clk, .reset_n, .od_index, .od_subindex, .od_write, .od_read, .od_wdata,
    .od_rdata, .od_rvalid, .accel_valid, .accel_x, .accel_y, .accel_z, .machine_valid, .machine_x,
    .machine_y, .machine_z, .capture_busy);
  iam_host_model host (.sys_clk, .od_index, .od_subindex, .od_write, .od_read, .od_wdata, .od_rdata,
    .od_rvalid);

  always #10 sys_clk = ~sys_clk;

  // ====================================================
  // Helpers
  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  // CORDIC leaves a few LSB of error
  function automatic logic [31:0] near(input int s, input int e);
    return 32'((s - e < 12 && e - s < 12) ? e : s);
  endfunction : near

  // Turn a pair by minus q quarter turns
  function automatic void turn(inout int a, inout int b, input int q);
    int t;
    repeat (((q % 4) + 4) % 4) begin
      t = a;
      a = b;
      b = -t;
    end
  endfunction : turn

  task automatic rchk(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
    logic [31:0] d;
    logic        v;
    host.rd(idx, sub, d, v);
    check(32'(v), 32'h1);
    check(d, exp);
  endtask : rchk

  task automatic send(input int x, input int y, input int z, output int mx, output int my, output int mz);
    int n;
    @(posedge sys_clk);
    #1;
    accel_valid = 1'b1;
    accel_x = 16'(x);
    accel_y = 16'(y);
    accel_z = 16'(z);
    @(posedge sys_clk);
    #1;
    accel_valid = 1'b0;
    accel_x = ~accel_x;
    n = 0;
    while (machine_valid !== 1'b1 && n < 400) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(32'(n < 400), 32'h1);
    check(32'(^{machine_x, machine_y, machine_z} === 1'bx), 32'h0);
    mx = machine_x;
    my = machine_y;
    mz = machine_z;
  endtask : send

  task automatic trial(input int qy, input int qp, input int qr, input int ir, input int ip, input logic vt);
    int x, y, z, t, mx, my, mz;
    x = int'($urandom_range(6000)) - 3000;
    y = int'($urandom_range(6000)) - 3000;
    z = int'($urandom_range(6000)) - 3000;
    host.wr(IDX_ROT_YAW, 32'(qy * 90 * 65536));
    host.wr(IDX_ROT_PITCH, 32'(qp * 90 * 65536));
    host.wr(IDX_ROT_ROLL, 32'(qr * 90 * 65536));
    host.wr(IDX_INIT_ROLL, {24'h0, 8'(ir * 90)});
    host.wr(IDX_INIT_PITCH, 32'(ip * 90 * 65536));
    host.wr(IDX_VERTICAL_MOUNT, {31'h0, vt});
    send(x, y, z, mx, my, mz);
    if (vt) begin
      t = x;
      x = y;
      y = z;
      z = t;
    end
    turn(x, y, qy);
    turn(z, x, qp);
    turn(z, y, qr);
    turn(z, y, ir);
    turn(z, x, ip);
    check(near(mx, x), 32'(x));
    check(near(my, y), 32'(y));
    check(near(mz, z), 32'(z));
  endtask : trial

  // ====================================================
  // Main sequence
  initial begin
    logic [31:0] w, d;
    logic        v;
    int          mx, my, mz;
    void'($urandom(32'hb5df));
    idx_tab = '{IDX_INIT_PITCH, IDX_INIT_ROLL, IDX_VERTICAL_MOUNT, IDX_ROT_YAW, IDX_ROT_PITCH,
      IDX_ROT_ROLL, IDX_LEVEL_CAPTURE};
    reset_n = 1'b0;
    accel_valid = 1'b0;
    accel_x = 16'h0;
    accel_y = 16'h0;
    accel_z = 16'h0;
    repeat (6) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    foreach (idx_tab[i]) rchk(idx_tab[i], SUBIDX_VALUE, 32'h0);
    foreach (idx_tab[i]) begin
      w = $urandom_range(32'h0168_0000) - 32'h00b4_0000;
      if (i == 6) w = {24'h0, LEVEL_NO};
      host.wr(idx_tab[i], w);
      rchk(idx_tab[i], SUBIDX_VALUE, (i inside {1, 2, 6}) ? {24'h0, w[7:0]} : w);
    end
    rchk(16'h2260, SUBIDX_VALUE, 32'h0);
    rchk(IDX_ROT_YAW, 8'h01, 32'h0);
    trial(0, 0, 0, 0, 0, 1'b0);
    trial(1, 1, 0, 0, 0, 1'b0);
    trial(0, 0, 0, 1, 1, 1'b1);
    repeat (10) trial(int'($urandom_range(4)) - 2, int'($urandom_range(4)) - 2, int'($urandom_range(4)) - 2,
      int'($urandom_range(2)) - 1, int'($urandom_range(2)) - 1, 1'($urandom_range(1)));
    trial(0, 0, 0, 0, 0, 1'b0);
    for (int i = 0; i < 2; i++) begin
      host.capture();
      @(posedge sys_clk);
      #1;
      check(32'(capture_busy), 32'h1);
      rchk(IDX_LEVEL_CAPTURE, SUBIDX_VALUE, 32'h0);
      send(4000 * (1 - i), 4000 * i, 4000, mx, my, mz);
      check(near(mx, 0), 32'h0);
      check(near(my, 0), 32'h0);
      check(32'(capture_busy), 32'h0);
      host.rd(IDX_INIT_PITCH, SUBIDX_VALUE, d, v);
      check(32'(d + HALF_LSB) >> 16, 32'(45 * (1 - i)));
      rchk(IDX_INIT_ROLL, SUBIDX_VALUE, 32'(45 * i));
    end
    host.wr(IDX_INIT_PITCH, 32'h0);
    rchk(IDX_INIT_PITCH, SUBIDX_VALUE, 32'h0);
    report_and_stop();
  end

  initial begin
    #(20 * 40000);
    err_total++;
    report_and_stop();
  end
endmodule : test_installation_angle_compensation
`default_nettype wire
